// ==== src/sbst_pkg.sv ====
/*
 * Shared constants and types for the SRAM boundary-scan TAP:
 * instruction codes, chain lengths, cell positions and the layout
 * of the identification word.
 * Assumes nothing of its surroundings; holds definitions only.
 */
package sbst_pkg;

    // scan path lengths
    localparam int IR_LEN = 3;
    localparam int ID_LEN = 32;
    localparam int BSR_LEN = 73;
    localparam int RING_PINS = 71;

    // tied cells, zero-based chain index (cell n sits at index n-1)
    localparam int CELL_VSS_IDX = 64;
    localparam int CELL_VDD_IDX = 69;

    // instruction codes
    localparam logic [2:0] INS_EXTEST = 3'h0;
    localparam logic [2:0] INS_IDCODE = 3'h1;
    localparam logic [2:0] INS_SAMPLE_Z = 3'h2;
    localparam logic [2:0] INS_SAMPLE = 3'h4;
    localparam logic [2:0] INS_BYPASS = 3'h7;

    // fixed pattern loaded into the instruction shifter on capture
    localparam logic [2:0] IR_CAPTURE = 3'h1;

    // fixed values of the chain
    localparam logic ID_PRESENT = 1'b1;
    localparam logic BYPASS_CAPTURE = 1'b0;
    localparam logic CELL_VSS_LEVEL = 1'b0;
    localparam logic CELL_VDD_LEVEL = 1'b1;

    // synchroniser depth
    localparam int SYNC_STAGES = 2;

    // identification word, bit 31 first
    typedef struct packed {
        logic [2:0] revision;   // 31:29
        logic [4:0] depth;      // 28:24
        logic [5:0] mem_type;   // 23:18
        logic [5:0] width_dens; // 17:12
        logic [10:0] maker;     // 11:1
        logic present;          // 0
    } sbst_id_s;

    // tap controller states, one-hot
    typedef enum logic [15:0] {
        ST_TLR = 16'h0001,
        ST_RTI = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SH_DR = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PA_DR = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PA_IR = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } sbst_state_e;

endpackage

// ==== src/sbst_sync.sv ====
/*
 * Multi-bit level synchroniser: a chain of flip-flops per bit.
 * Assumes each bit is an independent level; a word whose bits move
 * together may be caught half old, half new.
 */
`timescale 1ns/1ps
module sbst_sync #(
    parameter int WIDTH = 1,
    parameter int STAGES = sbst_pkg::SYNC_STAGES
) (
    input wire logic i_clk,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] stage_r [STAGES];

    // refuse depths that cannot resolve metastability
    if (STAGES < 2 || WIDTH < 1) begin : g_bad_param
        $error("sbst_sync: STAGES must be >= 2, WIDTH >= 1");
    end

    // first stage feeds only the second
    always_ff @(posedge i_clk) begin
        stage_r[0] <= i_async;
        for (int s = 1; s < STAGES; s++) begin
            stage_r[s] <= stage_r[s-1];
        end
    end

    assign o_sync = stage_r[STAGES-1];

endmodule

// ==== src/sbst_tap.sv ====
/*
 * Boundary-scan test access port of a synchronous SRAM.
 * Holds the tap controller, instruction register, bypass,
 * identification and boundary registers, and the high-z request
 * back into the memory clock domain.
 * Assumes i_tck is a free test clock unrelated to i_ref_clk, that
 * i_ring_pins are the raw pin levels of the memory, and that a
 * board-level wire resolves o_tdo with o_tdo_oe_n.
 */
`timescale 1ns/1ps
module sbst_tap #(
    // identification values below are arbitrary
    parameter logic [2:0] ID_REVISION = 3'h2,
    parameter logic [4:0] ID_DEPTH = 5'h03,
    parameter logic [5:0] ID_MEM_TYPE = 6'h02,
    parameter logic [5:0] ID_WIDTH_DENS = 6'h12,
    parameter logic [10:0] ID_MAKER = 11'h155
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    input wire logic [sbst_pkg::RING_PINS-1:0] i_ring_pins,
    output logic o_tdo,
    output logic o_tdo_oe_n,
    output logic o_mem_hiz
);

    // refuse identities and chain layouts the logic cannot serve
    if (ID_MAKER == 11'h7FF) begin : g_bad_maker
        $error("sbst_tap: ID_MAKER must not be all ones");
    end
    // the pin map assumes ring pins plus exactly two tied cells
    if (sbst_pkg::BSR_LEN != sbst_pkg::RING_PINS + 2) begin : g_bad_len
        $error("sbst_tap: chain must be ring pins plus two cells");
    end
    // the vss cell must come before the vdd cell
    if (sbst_pkg::CELL_VSS_IDX >= sbst_pkg::CELL_VDD_IDX
        || sbst_pkg::CELL_VDD_IDX >= sbst_pkg::BSR_LEN) begin : g_bad_cell
        $error("sbst_tap: tied cells out of order or out of range");
    end
    // a single flop would let metastability reach the controller
    if (sbst_pkg::SYNC_STAGES < 2) begin : g_bad_sync
        $error("sbst_tap: synchroniser needs two stages or more");
    end

    sbst_pkg::sbst_state_e state_r;
    sbst_pkg::sbst_state_e state_nxt;
    sbst_pkg::sbst_id_s id_word;
    logic tck_rst_n;
    logic [sbst_pkg::RING_PINS-1:0] ring_sync;
    logic [sbst_pkg::BSR_LEN-1:0] ring_cells;
    logic [sbst_pkg::IR_LEN-1:0] ir_shift_r;
    logic [sbst_pkg::IR_LEN-1:0] ir_r;
    logic bypass_r;
    logic [sbst_pkg::ID_LEN-1:0] id_shift_r;
    logic [sbst_pkg::BSR_LEN-1:0] bsr_r;
    logic hiz_tck_r;
    logic hiz_ref;
    logic sel_bsr;
    logic sel_id;
    logic dr_out;
    logic tdo_nxt;

    // memory reset into the test clock domain
    sbst_sync #(
        .WIDTH(1),
        .STAGES(sbst_pkg::SYNC_STAGES)
    ) u_rst_sync (
        .i_clk(i_tck),
        .i_async(i_rst_n),
        .o_sync(tck_rst_n)
    );

    // memory pins change on the fast clock; settle before capture
    sbst_sync #(
        .WIDTH(sbst_pkg::RING_PINS),
        .STAGES(sbst_pkg::SYNC_STAGES)
    ) u_ring_sync (
        .i_clk(i_tck),
        .i_async(i_ring_pins),
        .o_sync(ring_sync)
    );

    // high-z request into the memory clock domain
    sbst_sync #(
        .WIDTH(1),
        .STAGES(sbst_pkg::SYNC_STAGES)
    ) u_hiz_sync (
        .i_clk(i_ref_clk),
        .i_async(hiz_tck_r),
        .o_sync(hiz_ref)
    );

    // map pins onto cells, two cells tied to fixed levels
    for (genvar c = 0; c < sbst_pkg::BSR_LEN; c++) begin : g_cell
        if (c == sbst_pkg::CELL_VSS_IDX) begin : g_vss
            assign ring_cells[c] = sbst_pkg::CELL_VSS_LEVEL;
        end else if (c == sbst_pkg::CELL_VDD_IDX) begin : g_vdd
            assign ring_cells[c] = sbst_pkg::CELL_VDD_LEVEL;
        end else begin : g_pin
            localparam int P = c - (c > sbst_pkg::CELL_VSS_IDX ? 1 : 0)
                - (c > sbst_pkg::CELL_VDD_IDX ? 1 : 0);
            assign ring_cells[c] = ring_sync[P];
        end
    end

    // identification word fields
    always_comb begin
        id_word.revision = ID_REVISION;
        id_word.depth = ID_DEPTH;
        id_word.mem_type = ID_MEM_TYPE;
        id_word.width_dens = ID_WIDTH_DENS;
        id_word.maker = ID_MAKER;
        id_word.present = sbst_pkg::ID_PRESENT;
    end

    // controller next state from tms
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            sbst_pkg::ST_TLR:
                state_nxt = i_tms ? sbst_pkg::ST_TLR : sbst_pkg::ST_RTI;
            sbst_pkg::ST_RTI:
                state_nxt = i_tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_RTI;
            sbst_pkg::ST_SEL_DR:
                state_nxt = i_tms ? sbst_pkg::ST_SEL_IR
                    : sbst_pkg::ST_CAP_DR;
            sbst_pkg::ST_CAP_DR:
                state_nxt = i_tms ? sbst_pkg::ST_EX1_DR : sbst_pkg::ST_SH_DR;
            sbst_pkg::ST_SH_DR:
                state_nxt = i_tms ? sbst_pkg::ST_EX1_DR : sbst_pkg::ST_SH_DR;
            sbst_pkg::ST_EX1_DR:
                state_nxt = i_tms ? sbst_pkg::ST_UPD_DR : sbst_pkg::ST_PA_DR;
            sbst_pkg::ST_PA_DR:
                state_nxt = i_tms ? sbst_pkg::ST_EX2_DR : sbst_pkg::ST_PA_DR;
            sbst_pkg::ST_EX2_DR:
                state_nxt = i_tms ? sbst_pkg::ST_UPD_DR : sbst_pkg::ST_SH_DR;
            sbst_pkg::ST_UPD_DR:
                state_nxt = i_tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_RTI;
            sbst_pkg::ST_SEL_IR:
                state_nxt = i_tms ? sbst_pkg::ST_TLR : sbst_pkg::ST_CAP_IR;
            sbst_pkg::ST_CAP_IR:
                state_nxt = i_tms ? sbst_pkg::ST_EX1_IR : sbst_pkg::ST_SH_IR;
            sbst_pkg::ST_SH_IR:
                state_nxt = i_tms ? sbst_pkg::ST_EX1_IR : sbst_pkg::ST_SH_IR;
            sbst_pkg::ST_EX1_IR:
                state_nxt = i_tms ? sbst_pkg::ST_UPD_IR : sbst_pkg::ST_PA_IR;
            sbst_pkg::ST_PA_IR:
                state_nxt = i_tms ? sbst_pkg::ST_EX2_IR : sbst_pkg::ST_PA_IR;
            sbst_pkg::ST_EX2_IR:
                state_nxt = i_tms ? sbst_pkg::ST_UPD_IR : sbst_pkg::ST_SH_IR;
            sbst_pkg::ST_UPD_IR:
                state_nxt = i_tms ? sbst_pkg::ST_SEL_DR : sbst_pkg::ST_RTI;
            default:
                state_nxt = sbst_pkg::ST_TLR;
        endcase
    end

    // controller state on the rising test clock
    always_ff @(posedge i_tck) begin
        if (!tck_rst_n) begin
            state_r <= sbst_pkg::ST_TLR;
        end else begin
            state_r <= state_nxt;
        end
    end

    // instruction shifter: capture pattern, shift towards tdo
    always_ff @(posedge i_tck) begin
        if (!tck_rst_n) begin
            ir_shift_r <= sbst_pkg::IR_CAPTURE;
        end else if (state_r == sbst_pkg::ST_CAP_IR) begin
            ir_shift_r <= sbst_pkg::IR_CAPTURE;
        end else if (state_r == sbst_pkg::ST_SH_IR) begin
            ir_shift_r <= {i_tdi, ir_shift_r[sbst_pkg::IR_LEN-1:1]};
        end
    end

    // active instruction, id readout after reset
    always_ff @(posedge i_tck) begin
        if (!tck_rst_n || state_r == sbst_pkg::ST_TLR) begin
            ir_r <= sbst_pkg::INS_IDCODE;
        end else if (state_r == sbst_pkg::ST_UPD_IR) begin
            ir_r <= ir_shift_r;
        end
    end

    // path selection; reserved codes fall back to bypass
    always_comb begin
        sel_bsr = (ir_r == sbst_pkg::INS_EXTEST)
            || (ir_r == sbst_pkg::INS_SAMPLE_Z)
            || (ir_r == sbst_pkg::INS_SAMPLE);
        sel_id = (ir_r == sbst_pkg::INS_IDCODE);
    end

    // bypass cell, in path for 111 and unused codes
    always_ff @(posedge i_tck) begin
        if (!tck_rst_n) begin
            bypass_r <= sbst_pkg::BYPASS_CAPTURE;
        end else if (!sel_bsr && !sel_id) begin
            if (state_r == sbst_pkg::ST_CAP_DR) begin
                bypass_r <= sbst_pkg::BYPASS_CAPTURE;
            end else if (state_r == sbst_pkg::ST_SH_DR) begin
                bypass_r <= i_tdi;
            end
        end
    end

    // identification shifter, loaded on capture
    always_ff @(posedge i_tck) begin
        if (!tck_rst_n) begin
            id_shift_r <= id_word;
        end else if (sel_id) begin
            if (state_r == sbst_pkg::ST_CAP_DR) begin
                id_shift_r <= id_word;
            end else if (state_r == sbst_pkg::ST_SH_DR) begin
                id_shift_r <= {i_tdi, id_shift_r[sbst_pkg::ID_LEN-1:1]};
            end
        end
    end

    // boundary chain: capture ring, cell 1 exits first;
    // update-dr holds the chain since there is no preload stage
    always_ff @(posedge i_tck) begin
        if (!tck_rst_n) begin
            bsr_r <= '0;
        end else if (sel_bsr) begin
            if (state_r == sbst_pkg::ST_CAP_DR) begin
                bsr_r <= ring_cells;
            end else if (state_r == sbst_pkg::ST_SH_DR) begin
                bsr_r <= {i_tdi, bsr_r[sbst_pkg::BSR_LEN-1:1]};
            end else if (state_r == sbst_pkg::ST_UPD_DR) begin
                bsr_r <= bsr_r;
            end
        end
    end

    // high-z request follows the active instruction
    always_ff @(posedge i_tck) begin
        if (!tck_rst_n) begin
            hiz_tck_r <= 1'b0;
        end else begin
            hiz_tck_r <= (ir_r == sbst_pkg::INS_SAMPLE_Z);
        end
    end

    // memory-side copy of the high-z request
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_mem_hiz <= 1'b0;
        end else begin
            o_mem_hiz <= hiz_ref;
        end
    end

    // serial output source
    always_comb begin
        if (sel_bsr) begin
            dr_out = bsr_r[0];
        end else if (sel_id) begin
            dr_out = id_shift_r[0];
        end else begin
            dr_out = bypass_r;
        end
        tdo_nxt = (state_r == sbst_pkg::ST_SH_IR) ? ir_shift_r[0] : dr_out;
    end

    // tdo and its enable change on the falling test clock
    always_ff @(negedge i_tck) begin
        if (!tck_rst_n) begin
            o_tdo <= 1'b0;
            o_tdo_oe_n <= 1'b1;
        end else begin
            o_tdo <= tdo_nxt;
            o_tdo_oe_n <= !((state_r == sbst_pkg::ST_SH_IR)
                || (state_r == sbst_pkg::ST_SH_DR));
        end
    end

endmodule

// ==== bench/sbst_tap_sva.sv ====
/* checker for the scan port: shadow tap state, instruction and shift
   count on the test clock, with port relations asserted against them
   assumes it is bound to sbst_tap and sees its ports only */
`timescale 1ns/1ps
module sbst_tap_sva #(
    parameter logic [2:0] ID_REVISION = 3'h2,
    parameter logic [4:0] ID_DEPTH = 5'h03,
    parameter logic [5:0] ID_MEM_TYPE = 6'h02,
    parameter logic [5:0] ID_WIDTH_DENS = 6'h12,
    parameter logic [10:0] ID_MAKER = 11'h155
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_tck,
    input wire logic i_tms,
    input wire logic i_tdi,
    input wire logic [70:0] i_ring_pins,
    input wire logic o_tdo,
    input wire logic o_tdo_oe_n,
    input wire logic o_mem_hiz
);
    localparam logic [31:0] IDW = {ID_REVISION, ID_DEPTH, ID_MEM_TYPE,
        ID_WIDTH_DENS, ID_MAKER, 1'b1};
    // next state per nibble, tms low and tms high
    localparam logic [63:0] T0 = 64'h1BDD_BBA1_4664_4311;
    localparam logic [63:0] T1 = 64'h2FEF_CC02_8785_5920;
    logic [3:0] st_r;
    logic [2:0] ir_r;
    logic [2:0] irs_r;
    logic [6:0] cnt_r;
    logic bsr;
    // shadow tap state
    always_ff @(posedge i_tck) begin
        if (!i_rst_n) st_r <= 4'h0;
        else st_r <= i_tms ? T1[st_r*4+:4] : T0[st_r*4+:4];
    end
    // shadow instruction, forced to id readout in reset state
    always_ff @(posedge i_tck) begin
        if (!i_rst_n || st_r == 4'h0) ir_r <= 3'h1;
        else if (st_r == 4'hF) ir_r <= irs_r;
    end
    // shadow instruction shifter
    always_ff @(posedge i_tck) begin
        if (st_r == 4'hA) irs_r <= 3'h1;
        else if (st_r == 4'hB) irs_r <= {i_tdi, irs_r[2:1]};
    end
    // bits shifted since capture
    always_ff @(posedge i_tck) begin
        if (st_r == 4'h3) cnt_r <= 7'h00;
        else if (st_r == 4'h4) cnt_r <= cnt_r + 7'h01;
    end
    assign bsr = (ir_r == 3'h0 || ir_r == 3'h2 || ir_r == 3'h4) &&
        st_r == 4'h4;
    sequence s_hiz_ir;
        (ir_r == 3'h2) [*3];
    endsequence
    sequence s_nohiz_ir;
        (ir_r != 3'h2) [*3];
    endsequence
    property p_oe_shift;
        @(posedge i_tck) disable iff (!i_rst_n)
        o_tdo_oe_n == !(st_r == 4'h4 || st_r == 4'hB);
    endproperty
    property p_ir_cap;
        @(posedge i_tck) disable iff (!i_rst_n)
        (st_r == 4'hB && $past(st_r) == 4'hA) |-> o_tdo;
    endproperty
    property p_id_bits;
        @(posedge i_tck) disable iff (!i_rst_n)
        (ir_r == 3'h1 && st_r == 4'h4 && cnt_r < 7'h20)
            |-> o_tdo == IDW[cnt_r[4:0]];
    endproperty
    property p_byp_first;
        @(posedge i_tck) disable iff (!i_rst_n)
        (ir_r == 3'h7 && st_r == 4'h4 && cnt_r == 7'h00) |-> !o_tdo;
    endproperty
    property p_byp_pass;
        @(posedge i_tck) disable iff (!i_rst_n)
        (ir_r == 3'h7 && st_r == 4'h4 && cnt_r != 7'h00)
            |-> o_tdo == $past(i_tdi);
    endproperty
    property p_vss_cell;
        @(posedge i_tck) disable iff (!i_rst_n)
        (bsr && cnt_r == 7'h40) |-> !o_tdo;
    endproperty
    property p_vdd_cell;
        @(posedge i_tck) disable iff (!i_rst_n)
        (bsr && cnt_r == 7'h45) |-> o_tdo;
    endproperty
    property p_hiz_on;
        @(posedge i_tck) disable iff (!i_rst_n) s_hiz_ir |-> o_mem_hiz;
    endproperty
    property p_hiz_off;
        @(posedge i_tck) disable iff (!i_rst_n) s_nohiz_ir |-> !o_mem_hiz;
    endproperty
    property p_tdo_hold;
        @(posedge i_ref_clk) disable iff (!i_rst_n)
        (i_tck && $past(i_tck)) |-> $stable(o_tdo);
    endproperty
    a_oe_shift: assert property (p_oe_shift)
        else $error("tdo enable outside shift states");
    a_ir_cap: assert property (p_ir_cap)
        else $error("instruction capture bit wrong");
    a_id_bits: assert property (p_id_bits)
        else $error("id word bit wrong");
    a_byp_first: assert property (p_byp_first)
        else $error("bypass capture not zero");
    a_byp_pass: assert property (p_byp_pass)
        else $error("bypass path not one bit");
    a_vss_cell: assert property (p_vss_cell)
        else $error("ground cell not low");
    a_vdd_cell: assert property (p_vdd_cell)
        else $error("supply cell not high");
    a_hiz_on: assert property (p_hiz_on)
        else $error("memory outputs not off");
    a_hiz_off: assert property (p_hiz_off)
        else $error("memory outputs off wrongly");
    a_tdo_hold: assert property (p_tdo_hold)
        else $error("tdo moved while tck high");
endmodule
bind sbst_tap sbst_tap_sva #(
    .ID_REVISION(ID_REVISION),
    .ID_DEPTH(ID_DEPTH),
    .ID_MEM_TYPE(ID_MEM_TYPE),
    .ID_WIDTH_DENS(ID_WIDTH_DENS),
    .ID_MAKER(ID_MAKER)
) i_sva (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_tck(i_tck),
    .i_tms(i_tms), .i_tdi(i_tdi), .i_ring_pins(i_ring_pins),
    .o_tdo(o_tdo), .o_tdo_oe_n(o_tdo_oe_n), .o_mem_hiz(o_mem_hiz));

// ==== bench/sbst_ctl_model.sv ====
/* scan controller model: free test clock, tms and tdi change on the
   falling edge, tdo taken on the rising edge
   assumes the bench resolves the tdo wire into i_tdo */
`timescale 1ns/1ps
module sbst_ctl_model (
    output logic o_tck,
    output logic o_tms,
    output logic o_tdi,
    input wire logic i_tdo
);
    // free test clock, offset from the memory clock
    initial begin
        o_tck = 1'b0;
        o_tms = 1'b1;
        o_tdi = 1'b0;
        #5;
        forever #16 o_tck = ~o_tck;
    end
    // one test clock: drive after falling edge, sample at rising edge
    task automatic step(input logic tms, input logic tdi,
        output logic tdo);
        @(negedge o_tck);
        o_tms <= tms;
        o_tdi <= tdi;
        @(posedge o_tck);
        tdo = i_tdo;
    endtask
    // five ones reach reset state from anywhere, then idle
    task automatic to_idle();
        logic d;
        repeat (5) step(1'b1, 1'b0, d);
        step(1'b0, 1'b0, d);
    endtask
    // idle to shift, n bits lsb first, update, back to idle
    task automatic scan(input logic is_ir, input int n,
        input logic [127:0] din, output logic [127:0] dout);
        logic d;
        dout = '0;
        step(1'b1, 1'b0, d);
        if (is_ir) step(1'b1, 1'b0, d);
        step(1'b0, 1'b0, d);
        step(1'b0, 1'b0, d);
        for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
        step(1'b1, 1'b0, d);
        step(1'b0, 1'b0, d);
    endtask
endmodule

// ==== bench/sbst_tap_tb_top.sv ====
/* self-checking bench: id readout, bypass, ring capture per code
   assumes the controller model on the link and the bound checker */
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin \
    n_errors++; $display("CHECK FAILED t=%0t got=%0h exp=%0h", \
    $time, (a), (b)); end end
module sbst_tap_tb_top;
    localparam logic [31:0] ID_EXP = {3'h2, 5'h03, 6'h02, 6'h12,
        11'h155, 1'b1};
    localparam logic [70:0] PAT = 71'h25_A5C3_3C96_F012_D87B;
    logic ref_clk, rst_n, tck, tms, tdi, tdo, tdo_oe_n, mem_hiz;
    logic tdo_last = 1'b0;
    logic [70:0] pins;
    logic [127:0] q;
    int n_errors = 0;
    int cmp_count = 0;
    wire tdo_w;
    sbst_tap #(.ID_REVISION(ID_EXP[31:29]), .ID_DEPTH(ID_EXP[28:24]),
        .ID_MEM_TYPE(ID_EXP[23:18]), .ID_WIDTH_DENS(ID_EXP[17:12]),
        .ID_MAKER(ID_EXP[11:1])) i_dut (.i_ref_clk(ref_clk),
        .i_rst_n(rst_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
        .i_ring_pins(pins), .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n),
        .o_mem_hiz(mem_hiz));
    sbst_ctl_model i_ctl (.o_tck(tck), .o_tms(tms), .o_tdi(tdi),
        .i_tdo(tdo_w));
    // released tdo wire shows the inverse of its last level
    always @* if (!tdo_oe_n) tdo_last = tdo;
    assign tdo_w = tdo_oe_n ? ~tdo_last : tdo;
    // memory clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // expected chain: pins around the two tied cells
    function automatic logic [72:0] chain(input logic [70:0] p);
        logic [72:0] c;
        c = '0;
        for (int i = 0; i < 71; i++)
            c[i < 64 ? i : (i < 68 ? i + 1 : i + 2)] = p[i];
        c[69] = 1'b1;
        return c;
    endfunction
    task automatic t_id();
        i_ctl.scan(1'b0, 32, 128'h0, q);
        `CHK(q[31:0], ID_EXP)
        `CHK(mem_hiz, 1'b0)
    endtask
    task automatic t_byp();
        i_ctl.scan(1'b1, 3, 128'h7, q);
        `CHK(q[2:0], 3'h1)
        i_ctl.scan(1'b0, 8, 128'hA5, q);
        `CHK(q[7:0], 8'h4A)
    endtask
    task automatic t_cap(input logic [2:0] code, input logic [70:0] p);
        @(posedge ref_clk) pins <= p;
        i_ctl.scan(1'b1, 3, {125'h0, code}, q);
        // hiz request: one test clock plus three memory clocks
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK(mem_hiz, code == 3'h2)
        i_ctl.scan(1'b0, 73, 128'h0, q);
        `CHK(q[72:0], chain(p))
        `CHK(mem_hiz, code == 3'h2)
    endtask
    task automatic wrap_up();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // main sequence; only defined codes are loaded
    initial begin
        rst_n = 1'b0;
        pins = '0;
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        i_ctl.to_idle();
        t_id();
        t_byp();
        t_cap(3'h0, PAT);
        t_cap(3'h4, ~PAT);
        t_cap(3'h2, PAT);
        i_ctl.to_idle();
        t_id();
        wrap_up();
    end
    // watchdog
    initial begin
        #100000;
        n_errors++;
        wrap_up();
    end
endmodule
